// *** hw/emb_bus.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "emb_consts.svh"
// Functional notes
// - Fetching starts at program address zero
// - Access select low at reset: all fetches external except enabled boot ROM hits
// - Beyond internal size fetches go external
// - Enabled boot ROM occupies F800 to FFFF
// - Bus enabled when config bits zero, one clear
// - Enabled bus shows every access on ports
// - Internal hits drive zeros in data phase
// - Fetches use program-store strobe only
// - Data reads/writes use port 3 strobes
// - Fetch 16-bit; pointer 16, indirect 8-bit
// - Page register held on high port
// - Low port multiplexed, actively driven pins
// - Address valid at latch strobe falling edge
// - Write data surrounds the write strobe
// - Read data sampled before strobe release
// - Bus mode takes high port and strobes
// - Configuration writable only in programming mode
// - GPIO default; attempted access leaves pins
// - Fetch drives PC high byte
module emb_bus #(
  parameter logic [16:0] INT_PROG_SIZE = `EMB_INT_SIZE_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        external_access_select_n_i,
  input  wire logic        prog_mode_i,
  input  wire logic        boot_rom_en_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_wdata_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        req_i,
  input  wire logic [1:0]  req_kind_i,
  input  wire logic        use_data_pointer_i,
  input  wire logic [15:0] program_counter_i,
  input  wire logic [15:0] data_pointer_i,
  input  wire logic [7:0]  indirect_addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  int_rdata_i,
  input  wire logic [7:0]  p0_gpio_i,
  input  wire logic [7:0]  p2_gpio_i,
  input  wire logic        p36_gpio_i,
  input  wire logic        p37_gpio_i,
  input  wire logic [7:0]  multiplexed_low_port_in_i,
  output logic      [7:0]  multiplexed_low_port_o,
  output logic             multiplexed_low_port_oe_o,
  output logic      [7:0]  high_address_port_o,
  output logic             address_latch_o,
  output logic             program_store_strobe_n_o,
  output logic             data_read_strobe_n_o,
  output logic             data_write_strobe_n_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             fetch_external_o,
  output logic      [7:0]  rdata_o,
  output logic      [7:0]  cfg_rdata_o,
  output logic      [7:0]  external_page_select_o
);
  emb_pkg::emb_phase_t phase;
  emb_pkg::emb_phase_t next_phase;
  emb_pkg::emb_kind_t  kind;
  logic [2:0]  cnt;
  logic        ext_hit;
  logic        all_ext;
  logic        strap_taken;
  logic [15:0] addr;
  logic [7:0]  page;
  logic [7:0]  cfg;

  emb_cfg_store u_cfg (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .prog_mode_i (prog_mode_i),
    .wr_i        (cfg_wr_i),
    .wdata_i     (cfg_wdata_i),
    .rdata_o     (cfg)
  );

  // Either config bit set keeps ports as GPIO; both clear enables the bus
  wire bus_en = ~cfg[`EMB_CFG_P2_BIT] & ~cfg[`EMB_CFG_P0_BIT];

  wire boot_hit = boot_rom_en_i && (program_counter_i >= `EMB_BOOT_BASE);
  wire pc_ext   = all_ext || ({1'b0, program_counter_i} >= INT_PROG_SIZE);
  wire fetch_ext = bus_en && pc_ext && !boot_hit;
  wire is_fetch = (req_kind_i == 2'(emb_pkg::EMB_FETCH));
  // Data accesses count as external whenever the bus is on
  wire req_ext  = is_fetch ? fetch_ext : bus_en;
  wire [15:0] req_addr = is_fetch ? program_counter_i :
                         use_data_pointer_i ? data_pointer_i :
                         {page, indirect_addr_i};
  wire phase_done = (cnt == `EMB_PHASE_CYCLES - 3'd1);
  wire start = (phase == emb_pkg::EMB_IDLE) && req_i;

  // Strap sampled on the first clock after reset release, not inside the reset branch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_taken <= 1'b0;
      all_ext     <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      all_ext     <= ~external_access_select_n_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      page <= `EMB_PAGE_RESET;
    end else if (sfr_wr_i && sfr_addr_i == `EMB_PAGE_ADDR) begin
      page <= sfr_wdata_i;
    end
  end

  // Address, latch, strobe and hold phases last EMB_PHASE_CYCLES core clocks; sample lasts one
  always_comb begin
    next_phase = phase;
    case (phase)
      emb_pkg::EMB_IDLE:   if (req_i) next_phase = emb_pkg::EMB_ADDR;
      emb_pkg::EMB_ADDR:   if (phase_done) next_phase = emb_pkg::EMB_LATCH;
      emb_pkg::EMB_LATCH:  if (phase_done) next_phase = emb_pkg::EMB_STROBE;
      emb_pkg::EMB_STROBE: if (phase_done) next_phase = emb_pkg::EMB_SAMPLE;
      emb_pkg::EMB_SAMPLE: next_phase = emb_pkg::EMB_HOLD;
      emb_pkg::EMB_HOLD:   if (phase_done) next_phase = emb_pkg::EMB_IDLE;
      default:             next_phase = emb_pkg::EMB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase   <= emb_pkg::EMB_IDLE;
      cnt     <= 3'd0;
      kind    <= emb_pkg::EMB_FETCH;
      addr    <= `EMB_RESET_PC;
      ext_hit <= 1'b0;
    end else begin
      phase <= next_phase;
      cnt   <= (next_phase != phase || phase == emb_pkg::EMB_IDLE) ? 3'd0 : cnt + 3'd1;
      if (start) begin
        kind    <= emb_pkg::emb_kind_t'(req_kind_i);
        addr    <= req_addr;
        ext_hit <= req_ext;
      end
    end
  end

  wire active   = (phase != emb_pkg::EMB_IDLE);
  wire show     = active && bus_en;
  wire addr_ph  = (phase == emb_pkg::EMB_ADDR) || (phase == emb_pkg::EMB_LATCH);
  wire strobe_ph = (phase == emb_pkg::EMB_STROBE) || (phase == emb_pkg::EMB_SAMPLE);
  wire wr_data_ph = strobe_ph || (phase == emb_pkg::EMB_HOLD) || (phase == emb_pkg::EMB_LATCH && cnt != 3'd0);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      multiplexed_low_port_o    <= 8'h00;
      multiplexed_low_port_oe_o <= 1'b0;
      high_address_port_o       <= 8'hFF;
      address_latch_o           <= 1'b0;
      program_store_strobe_n_o  <= 1'b1;
      data_read_strobe_n_o      <= 1'b1;
      data_write_strobe_n_o     <= 1'b1;
      busy_o                    <= 1'b0;
      done_o                    <= 1'b0;
      fetch_external_o          <= 1'b0;
      rdata_o                   <= 8'h00;
      cfg_rdata_o               <= `EMB_CFG_RESET;
      external_page_select_o    <= `EMB_PAGE_RESET;
    end else begin
      busy_o                 <= active;
      done_o                 <= (phase == emb_pkg::EMB_HOLD) && phase_done;
      fetch_external_o       <= fetch_ext;
      cfg_rdata_o            <= cfg;
      external_page_select_o <= page;
      // Latch strobe high through address phase, falls with address still driven
      address_latch_o <= show && (phase == emb_pkg::EMB_ADDR);
      // Port pins stay GPIO when the bus is off, even if an access is attempted
      high_address_port_o <= show ? addr[15:8] : p2_gpio_i;
      if (!show) begin
        multiplexed_low_port_o    <= p0_gpio_i;
        multiplexed_low_port_oe_o <= 1'b0;
      end else if (addr_ph && !(kind == emb_pkg::EMB_DATA_WR && phase == emb_pkg::EMB_LATCH && cnt != 3'd0)) begin
        multiplexed_low_port_o    <= addr[7:0];
        multiplexed_low_port_oe_o <= 1'b1;
      end else if (!ext_hit) begin
        multiplexed_low_port_o    <= 8'h00;
        multiplexed_low_port_oe_o <= 1'b1;
      end else if (kind == emb_pkg::EMB_DATA_WR && wr_data_ph) begin
        multiplexed_low_port_o    <= wdata_i;
        multiplexed_low_port_oe_o <= 1'b1;
      end else begin
        multiplexed_low_port_o    <= 8'h00;
        multiplexed_low_port_oe_o <= 1'b0;
      end
      program_store_strobe_n_o <= ~(show && ext_hit && strobe_ph && kind == emb_pkg::EMB_FETCH);
      data_read_strobe_n_o  <= show ? ~(ext_hit && strobe_ph && kind == emb_pkg::EMB_DATA_RD) : p37_gpio_i;
      data_write_strobe_n_o <= show ? ~(ext_hit && phase == emb_pkg::EMB_STROBE && kind == emb_pkg::EMB_DATA_WR)
                                    : p36_gpio_i;
      // Sample in last strobe cycle, just before release
      if (phase == emb_pkg::EMB_SAMPLE) begin
        rdata_o <= ext_hit ? multiplexed_low_port_in_i : int_rdata_i;
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/emb_consts.svh ***
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

`define EMB_RESET_PC        16'h0000
`define EMB_BOOT_BASE       16'hF800
`define EMB_BOOT_TOP        16'hFFFF
`define EMB_PAGE_ADDR       8'h92
`define EMB_PAGE_RESET      8'h00
`define EMB_CFG_P2_BIT      0
`define EMB_CFG_P0_BIT      1
`define EMB_CFG_RESET       8'hFF
`define EMB_INT_SIZE_DEF    17'h08000
`define EMB_PHASE_CYCLES    3'd4

`endif

// *** hw/emb_pkg.sv ***
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_FETCH,
    EMB_DATA_RD,
    EMB_DATA_WR
  } emb_kind_t;

  typedef enum logic [2:0] {
    EMB_IDLE,
    EMB_ADDR,
    EMB_LATCH,
    EMB_STROBE,
    EMB_SAMPLE,
    EMB_HOLD
  } emb_phase_t;
endpackage

// *** hw/emb_cfg_store.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "emb_consts.svh"
// Holds the hardware configuration byte; writable only in flash programming mode.
module emb_cfg_store (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       prog_mode_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `EMB_CFG_RESET;
    end else if (wr_i && prog_mode_i) begin
      rdata_o <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// *** verif/emb_bus_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module emb_bus_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       prog_mode_i,
  input wire logic       cfg_wr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic       address_latch_o,
  input wire logic       multiplexed_low_port_oe_o,
  input wire logic       program_store_strobe_n_o,
  input wire logic       data_read_strobe_n_o,
  input wire logic       data_write_strobe_n_o,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic [7:0] external_page_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    $rose(busy_o);
  endsequence
  sequence s_no_strobe;
    program_store_strobe_n_o && data_read_strobe_n_o && data_write_strobe_n_o;
  endsequence
  chk_cycle_ends: assert property (s_take |-> ##[1:40] done_o) else $error("cycle never done");
  chk_done_pulse: assert property (done_o |=> !done_o) else $error("done too long");
  chk_fetch_only: assert property (!program_store_strobe_n_o |->
    data_read_strobe_n_o && data_write_strobe_n_o) else $error("data strobe in fetch");
  chk_rd_wr_excl: assert property (data_read_strobe_n_o || data_write_strobe_n_o) else $error("rd and wr");
  chk_latch_idle: assert property (address_latch_o |-> s_no_strobe) else $error("strobe during latch");
  chk_addr_driven: assert property ($fell(address_latch_o) |-> multiplexed_low_port_oe_o)
    else $error("addr");
  chk_wr_setup: assert property ($fell(data_write_strobe_n_o) |-> $past(multiplexed_low_port_oe_o))
    else $error("write data late");
  chk_wr_hold: assert property ($rose(data_write_strobe_n_o) |-> multiplexed_low_port_oe_o)
    else $error("hold");
  // Page register and its output flop add two edges of latency
  chk_page_write: assert property (sfr_wr_i && sfr_addr_i == 8'h92 |->
    ##2 external_page_select_o == $past(sfr_wdata_i, 2)) else $error("page write lost");
  // Output copy lags the store by one edge, so look one edge later
  chk_cfg_locked: assert property (cfg_wr_i && !prog_mode_i |=> ##1 $stable(cfg_rdata_o)) else $error("cfg");
endmodule
`default_nettype wire

// *** verif/emb_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic [7:0] ad_i,
  input  wire logic [7:0] hi_i,
  input  wire logic       program_store_strobe_n_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  output logic      [7:0] ad_o
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic        ale_q;
  wire         rd_n = rd_n_i & program_store_strobe_n_n_i;
  initial ad_o = 8'hA5;
  always @(posedge clk_i) begin
    ale_q <= ale_i;
    if (ale_q && !ale_i) addr <= {hi_i, ad_i};
    if (!wr_n_i) mem[addr] <= ad_i;
    // Released bus toggles so a stale value never passes for data
    ad_o <= rd_n ? ~ad_o : mem[addr];
  end
endmodule
`default_nettype wire

// *** verif/emb_bus_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module emb_bus_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, external_access_select_n_i = 1'b1, prog_mode_i = 1'b0;
  logic        boot_rom_en_i = 1'b0, cfg_wr_i = 1'b0, sfr_wr_i = 1'b0, req_i = 1'b0, use_data_pointer_i = 1'b0;
  logic        p36_gpio_i = 1'b1, p37_gpio_i = 1'b1;
  logic [1:0]  req_kind_i = 2'h0;
  logic [7:0]  cfg_wdata_i = 8'h00, sfr_addr_i = 8'h92, sfr_wdata_i = 8'h00, indirect_addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00, int_rdata_i = 8'hC3, p0_gpio_i = 8'h0F, p2_gpio_i = 8'h6B;
  logic [15:0] program_counter_i = 16'h0000, data_pointer_i = 16'h0000;
  logic [7:0]  multiplexed_low_port_o, high_address_port_o, rdata_o, cfg_rdata_o, external_page_select_o, mem_ad;
  logic        multiplexed_low_port_oe_o, address_latch_o, program_store_strobe_n_o, data_read_strobe_n_o;
  logic        data_write_strobe_n_o, busy_o, done_o, fetch_external_o, s_ps, s_rd, s_wr;
  logic [7:0]  hi;
  logic [8:0]  lo;
  wire  [7:0]  multiplexed_low_port_in_i = multiplexed_low_port_oe_o ? multiplexed_low_port_o : mem_ad;
  int          fails = 0, checks = 0, cyc = 0;
  emb_bus dut_u (.*);
  emb_mem_model mem_u (.clk_i, .ale_i(address_latch_o), .ad_i(multiplexed_low_port_o), .hi_i(high_address_port_o),
    .program_store_strobe_n_n_i(program_store_strobe_n_o), .rd_n_i(data_read_strobe_n_o), .wr_n_i(data_write_strobe_n_o), .ad_o(mem_ad));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset(input logic ea_n);
    rst_i <= 1'b1;
    external_access_select_n_i <= ea_n;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Strobes and high port are sampled mid-cycle, away from the launching edge
  task automatic op(input logic [1:0] k);
    req_kind_i <= k;
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    {s_ps, s_rd, s_wr} = 3'h0;
    repeat (40) begin
      @(negedge clk_i);
      if (program_store_strobe_n_o === 1'b0) s_ps = 1'b1;
      if (data_read_strobe_n_o === 1'b0) s_rd = 1'b1;
      if (data_write_strobe_n_o === 1'b0) s_wr = 1'b1;
      if (address_latch_o === 1'b1) hi = high_address_port_o;
      if (done_o === 1'b1) begin
        lo = {multiplexed_low_port_oe_o, multiplexed_low_port_o};
        break;
      end
    end
    `CHK("done", done_o, 1'b1)
    @(posedge clk_i);
  endtask
  task automatic t_bus_off();
    `CHK("cfg", cfg_rdata_o, 8'hFF)
    `CHK("page", external_page_select_o, 8'h00)
    program_counter_i <= 16'h8000;
    op(2'h0);
    `CHK("strb", {s_ps, s_rd, s_wr}, 3'h0)
    `CHK("ext", fetch_external_o, 1'b0)
    `CHK("p2", high_address_port_o, p2_gpio_i)
    `CHK("p0", multiplexed_low_port_o, p0_gpio_i)
  endtask
  task automatic t_cfg();
    cfg_wdata_i <= 8'h00;
    prog_mode_i <= 1'b1;
    cfg_wr_i <= 1'b1;
    @(posedge clk_i);
    prog_mode_i <= 1'b0;
    cfg_wdata_i <= 8'hFF;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    // Wait until a refused write would have reached the output copy
    @(posedge clk_i);
    @(posedge clk_i);
    `CHK("cfg", cfg_rdata_o, 8'h00)
  endtask
  task automatic t_fetch();
    logic [15:0] pcs [4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hF900};
    mem_u.mem[16'h8000] = 8'h3C;
    for (int i = 0; i < 4; i++) begin
      program_counter_i <= pcs[i];
      boot_rom_en_i <= (i == 3);
      op(2'h0);
      `CHK("ext", fetch_external_o, (i == 2))
      `CHK("strb", {s_ps, s_rd, s_wr}, {(i == 2), 2'h0})
      `CHK("hi", hi, pcs[i][15:8])
      `CHK("lo", lo, (i == 2) ? 9'h000 : 9'h100)
      `CHK("rdata", rdata_o, (i == 2) ? 8'h3C : 8'hC3)
    end
  endtask
  task automatic t_data();
    data_pointer_i <= 16'h1234;
    wdata_i <= 8'h5A;
    use_data_pointer_i <= 1'b1;
    op(2'h2);
    `CHK("wr", {s_ps, s_rd, s_wr}, 3'h1)
    `CHK("mem", mem_u.mem[16'h1234], 8'h5A)
    sfr_wdata_i <= 8'h12;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    indirect_addr_i <= 8'h34;
    use_data_pointer_i <= 1'b0;
    op(2'h1);
    `CHK("rd", {s_ps, s_rd, s_wr}, 3'h2)
    `CHK("rdata", rdata_o, 8'h5A)
    `CHK("hi", hi, 8'h12)
  endtask
  task automatic t_strap();
    do_reset(1'b0);
    // Reset returns the ports to GPIO, so the bus is enabled again first
    t_cfg();
    program_counter_i <= 16'h0000;
    op(2'h0);
    `CHK("strap", fetch_external_o, 1'b1)
    `CHK("strb", {s_ps, s_rd, s_wr}, 3'h4)
  endtask
  initial begin
    do_reset(1'b1);
    t_bus_off();
    t_cfg();
    t_fetch();
    t_data();
    t_strap();
    end_of_test();
  end
endmodule
bind emb_bus emb_bus_chk chk_u (.*);
`default_nettype wire
